// ---- hdl/period_timer_pkg.sv ----
// Constants for the prescaled 8-bit period timer
`default_nettype none
package period_timer_pkg;
  // ********************
  // Register indices (printed offsets, byte address is four times)
  // ********************
  localparam logic [7:0] IDX_FLAGS   = 8'h0C;
  localparam logic [7:0] IDX_COUNT   = 8'h11;
  localparam logic [7:0] IDX_CONTROL = 8'h12;
  localparam logic [7:0] IDX_ENABLES = 8'h8C;
  localparam logic [7:0] IDX_PERIOD  = 8'h92;
  // ********************
  // Reset values
  // ********************
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_COUNT   = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_PERIOD  = 8'hFF;
  // ********************
  // Field positions
  // ********************
  localparam int          POS_RUN       = 2;
  localparam int          POS_MATCH_LO  = 3;
  localparam int          POS_MATCH_FLG = 1;
  localparam logic [7:0]  CONTROL_MASK  = 8'h7F;
  localparam logic [7:0]  FLAGS_MASK    = 8'h02;
  localparam logic [7:0]  ENABLES_MASK  = 8'h02;
  // ********************
  // Instruction clock and prescale counts
  // ********************
  localparam logic [1:0]  INSTR_DIV_LAST = 2'h3;
  localparam logic [3:0]  PRE_LAST_4     = 4'h3;
  localparam logic [3:0]  PRE_LAST_16    = 4'hF;
  localparam logic [3:0]  PRE_LAST_1     = 4'h0;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
endpackage
`default_nettype wire

// ---- hdl/event_divider.sv ----
// Counts enable events and fires once every (last+1) events
`default_nettype none
module event_divider
  import period_timer_pkg::*;
#(
  parameter int W = 4
)
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clear,
  input  wire logic         event_in,
  input  wire logic [W-1:0] last,
  output logic              fire
);
  logic [W-1:0] count;

  assign fire = event_in && (count >= last);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= '0;
    else if (clear)
      count <= '0;
    else if (fire)
      count <= '0;
    else if (event_in)
      count <= count + 1'b1;
  end
endmodule
`default_nettype wire

// ---- hdl/period_timer.sv ----
// AHB-Lite prescaled 8-bit period timer with postscaled match flag
//
// Implementation choice: the AHB-Lite interface to the registers.
`default_nettype none
// Behaviour
// - The counter counts up from zero per tick and after equalling the period goes back to zero.
// - The period register is 8-bit read/write and resets to all ones.
// - Control bits 1:0 pick tick divide of 1 (00), 4 (01) or 16 (1x) from the instruction clock.
// - Control bits 6:3 divide match events by field value plus one.
// - Each postscaler output sets the match flag in bit 1 of the peripheral flags.
// - Writes to the counter or control register, and reset, clear both scaler counters.
// - A control write leaves the counter value unchanged.
// - The counter is read/write and resets to zero.
// - Control bit 2 runs the timer when set and stops it when clear.
// - The match before the postscaler goes out as a shift clock source for the serial port.
// - Period match and counter reset form the time base for the PWM unit.
// - Control bit 7 reads zero and ignores writes.
module period_timer
  import period_timer_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             shift_clock_tick,
  output logic             pwm_period_match,
  output logic [7:0]       pwm_time_base
);
  // ********************
  // Registers
  // ********************
  logic [7:0] timer_count;
  logic [7:0] period_limit;
  logic [7:0] timer_control;
  logic [7:0] peripheral_flags;
  logic [7:0] peripheral_enables;
  logic [1:0] instr_div;
  logic [3:0] pre_count;
  logic       wr_pend;
  logic [7:0] wr_index;

  // ********************
  // Bus decode
  // ********************
  wire        addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  wire [7:0]  addr_idx  = haddr[9:2];
  wire        wr_flags   = wr_pend && (wr_index == IDX_FLAGS);
  wire        wr_count   = wr_pend && (wr_index == IDX_COUNT);
  wire        wr_control = wr_pend && (wr_index == IDX_CONTROL);
  wire        wr_enables = wr_pend && (wr_index == IDX_ENABLES);
  wire        wr_period  = wr_pend && (wr_index == IDX_PERIOD);
  wire [7:0]  wdata8     = hwdata[7:0];

  // Reads come straight from state in the data phase; unmapped reads as zero
  wire [7:0]  rd_sel =
    (wr_index == IDX_FLAGS)   ? peripheral_flags :
    (wr_index == IDX_COUNT)   ? timer_count :
    (wr_index == IDX_CONTROL) ? (timer_control & CONTROL_MASK) :
    (wr_index == IDX_ENABLES) ? peripheral_enables :
    (wr_index == IDX_PERIOD)  ? period_limit : 8'h00;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, rd_sel};

  // ********************
  // Tick generation
  // ********************
  wire [1:0] input_divide_select = timer_control[1:0];
  wire [3:0] match_divide_select = timer_control[POS_MATCH_LO +: 4];
  wire       timer_run           = timer_control[POS_RUN];
  wire       scaler_clear        = wr_count || wr_control;
  wire       instr_tick          = (instr_div == INSTR_DIV_LAST);
  wire [3:0] pre_last =
    input_divide_select[1]   ? PRE_LAST_16 :
    (input_divide_select[0]) ? PRE_LAST_4 : PRE_LAST_1;
  // Stopped timer freezes the prescaler too; only the instruction clock divider keeps counting
  wire       pre_event = instr_tick && timer_run;
  wire       count_tick = pre_event && (pre_count >= pre_last);
  wire       match      = (timer_count == period_limit);
  wire       wrap       = count_tick && match;
  wire       post_fire;
  wire [7:0] next_count = wrap ? 8'h00 : timer_count + 8'h01;

  assign shift_clock_tick = wrap;
  assign pwm_period_match = wrap;
  assign pwm_time_base    = timer_count;

  event_divider #(.W(4)) postscaler
  (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .clear    (scaler_clear),
    .event_in (wrap),
    .last     (match_divide_select),
    .fire     (post_fire)
  );

  // ********************
  // Sequential logic
  // ********************
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend  <= 1'b0;
      wr_index <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend  <= addr_take && hwrite;
      wr_index <= addr_take ? addr_idx : 8'hFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      instr_div <= 2'h0;
    else
      instr_div <= instr_div + 2'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_count <= 4'h0;
    else if (scaler_clear)
      pre_count <= 4'h0;
    else if (count_tick)
      pre_count <= 4'h0;
    else if (pre_event)
      pre_count <= pre_count + 4'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_count <= RST_COUNT;
    else if (wr_count)
      timer_count <= wdata8;
    else if (count_tick)
      timer_count <= next_count;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      timer_control <= RST_CONTROL;
    else if (wr_control)
      timer_control <= wdata8 & CONTROL_MASK;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      period_limit <= RST_PERIOD;
    else if (wr_period)
      period_limit <= wdata8;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      peripheral_enables <= RST_ENABLES;
    else if (wr_enables)
      peripheral_enables <= wdata8 & ENABLES_MASK;
  end

  // Hardware set beats a same-cycle software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      peripheral_flags <= RST_FLAGS;
    else if (post_fire)
      peripheral_flags[POS_MATCH_FLG] <= 1'b1;
    else if (wr_flags)
      peripheral_flags <= wdata8 & FLAGS_MASK;
  end
endmodule
`default_nettype wire

// ---- sim/period_timer_asserts.sv ----
// Port assertions for the period timer
`default_nettype none
module period_timer_asserts (
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic        shift_clock_tick, pwm_period_match,
  input wire logic [1:0]  htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [7:0]  pwm_time_base
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic dp_wr;
  // Write data phase: software may move the count
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) dp_wr <= 1'b0;
    else dp_wr <= hsel && hready && htrans == 2'h2 && hwrite;
  sequence s_req(w, a);
    hsel && hready && htrans == 2'h2 && hwrite == w && haddr == a;
  endsequence
  property p_cnt_wr;
    logic [7:0] v;
    (s_req(1'b1, 32'h44) ##1 (1'b1, v = hwdata[7:0])) |=> pwm_time_base == v;
  endproperty
  chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus not okay");
  chk_tick_pair: assert property (shift_clock_tick == pwm_period_match) else $error("pair");
  chk_wrap_zero:
    assert property (shift_clock_tick && !dp_wr |=> pwm_time_base == 8'h00) else $error("wrap");
  chk_count_step:
    assert property ($changed(pwm_time_base) && !$past(dp_wr) |-> pwm_time_base == 8'h00
      || pwm_time_base == $past(pwm_time_base) + 8'h01) else $error("count step");
  chk_count_write: assert property (p_cnt_wr) else $error("count write");
  chk_count_read: assert property (s_req(1'b0, 32'h44) |=> hrdata == {24'h0, pwm_time_base})
    else $error("count read");
  chk_ctl_bit7: assert property (s_req(1'b0, 32'h48) |=> !hrdata[7]) else $error("bit 7");
  chk_stop_hold:
    assert property (s_req(1'b1, 32'h48) ##1 !hwdata[2] |=> ##1 $stable(pwm_time_base)[*2])
      else $error("stopped count moved");
endmodule
bind period_timer period_timer_asserts chk (.*);
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the period timer
`default_nettype none
module tb_top import period_timer_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic             hclk, hresetn, hsel, hwrite;
  logic [1:0]       htrans;
  logic [31:0]      haddr, hwdata, rd_q;
  wire logic        hreadyout, hresp, shift_clock_tick;
  wire logic [31:0] hrdata;
  wire logic [7:0]  pwm_time_base;
  int               num_errors, compares, gap, per, pre, ps;
  period_timer dut (.*, .hsize(3'h2), .hready(hreadyout), .pwm_period_match());
  // Edges since the last wrap, read before this edge updates it
  always @(posedge hclk)
    gap <= shift_clock_tick ? 1 : gap + 1;
  // Read data as it stood at the edge closing the data phase
  always @(posedge hclk)
    rd_q <= hrdata;
  function automatic int span(int p, int c);
    return (p + 1) * 4 * (c == 0 ? 1 : c == 1 ? 4 : 16);
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads compare with d; writes drive d
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    {hsel, hwrite, haddr, htrans} <= {1'b1, w, a, HTRANS_NONSEQ};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    @(negedge hclk);
    if (!w)
      chk(rd_q, d);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial
  begin
    #1000000 num_errors++;
    conclude();
  end
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, num_errors, compares, gap} = '0;
    void'($urandom(62));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 32'h248, 32'hFF);
    bus(1'b0, 32'h44, 32'h0);
    bus(1'b0, 32'h30, 32'h0);
    bus(1'b1, 32'h48, 32'hFF);
    bus(1'b0, 32'h48, 32'h7F);
    bus(1'b1, 32'h48, 32'h0);
    bus(1'b1, 32'h44, 32'h5A);
    bus(1'b1, 32'h48, 32'h1);
    repeat (300) @(posedge hclk);
    bus(1'b0, 32'h44, 32'h5A);
    // Stop first, so no wrap sneaks in before the flag is cleared
    for (int i = 0; i < 5; i++)
    begin
      per = 3 + $urandom_range(7);
      pre = i % 4;
      ps = i == 0 ? 15 : i == 1 ? 0 : $urandom_range(15);
      bus(1'b1, 32'h48, 32'h0);
      bus(1'b1, 32'h44, 32'h0);
      bus(1'b1, 32'h248, 32'(per));
      bus(1'b0, 32'h248, 32'(per));
      bus(1'b1, 32'h48, 32'(ps * 8 + 4 + pre));
      bus(1'b1, 32'h30, 32'h0);
      for (int k = 1; k <= ps + 2; k++)
      begin
        for (int c = 0; c < 5000 && shift_clock_tick !== 1'b1; c++)
          @(posedge hclk);
        if (k > 1)
          chk(32'(gap), 32'(span(per, pre)));
        bus(1'b0, 32'h30, k > ps ? 32'h2 : 32'h0);
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
